// ### logic/mtb_touch_qualify.sv
// Touch qualifier: simultaneous touch limit, pattern detect, APB registers
`timescale 1ns/100ps
module mtb_touch_qualify
    import mtb_pkg::*;
#(
    parameter int N = NUM_INPUTS
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Polling cycle results
    input wire logic sample_valid,
    input wire mtb_sample_t sample,
    // Qualified outputs
    output mtb_result_t result,
    output logic irq
);
    // Percentage of base threshold, truncated
    function automatic logic [TH_W-1:0] pct(input logic [TH_W-1:0] b, input logic [1:0] s);
        logic [TH_W+1:0] w;
        w = {2'b00, b};
        unique case (s)
            2'b00: pct = TH_W'(w >> 3);
            2'b01: pct = TH_W'(w >> 2);
            2'b10: pct = TH_W'((w + (w << 1)) >> 3);
            2'b11: pct = b;
        endcase
    endfunction

    // Noise fraction of touch threshold, truncated
    function automatic logic [TH_W-1:0] npct(input logic [TH_W-1:0] b, input logic [1:0] s);
        logic [TH_W+2:0] w;
        w = {3'b000, b};
        unique case (s)
            2'b00: npct = TH_W'(w >> 2);
            2'b01: npct = TH_W'((w + (w << 1)) >> 3);
            2'b10: npct = TH_W'(w >> 1);
            2'b11: npct = TH_W'((w + (w << 2)) >> 3);
        endcase
    endfunction

    // Population count of six bits
    function automatic logic [2:0] ones(input logic [N-1:0] v);
        ones = 3'h0;
        for (int i = 0; i < N; i++)
        begin
            ones = ones + {2'b00, v[i]};
        end
    endfunction

    // Registers
    logic [7:0] limit_cfg_reg;
    logic [7:0] pat_cfg_reg;
    logic [7:0] pat_sel_reg;
    logic [7:0] noise_cfg_reg;
    logic [1:0] status_reg;
    logic [1:0] status_next;
    logic [1:0] int_en_reg;
    logic [N-1:0] accept_reg;
    logic [N-1:0] accept_next;
    logic [N-1:0] touch_out_reg;
    logic [N-1:0] touch_out_next;
    logic pat_block_reg;
    logic pat_block_next;
    logic irq_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;

    // APB decode
    wire logic [9:0] word_idx = paddr[11:2];
    wire logic setup = psel && !penable;
    wire logic acc = psel && penable && pready_reg;
    wire logic wr = acc && pwrite;
    wire logic hit_limit = word_idx == {2'b00, IDX_LIMIT_CFG};
    wire logic hit_pcfg = word_idx == {2'b00, IDX_PAT_CFG};
    wire logic hit_psel = word_idx == {2'b00, IDX_PAT_SEL};
    wire logic hit_stat = word_idx == {2'b00, IDX_STATUS};
    wire logic hit_ien = word_idx == {2'b00, IDX_INT_EN};
    wire logic hit_iclr = word_idx == {2'b00, IDX_INT_CLR};
    wire logic hit_acc = word_idx == {2'b00, IDX_ACCEPT};
    wire logic hit_noise = word_idx == {2'b00, IDX_NOISE_CFG};
    wire logic mapped = hit_limit | hit_pcfg | hit_psel | hit_stat | hit_ien | hit_iclr
        | hit_acc | hit_noise;
    wire logic [1:0] clr_bits = (wr && hit_iclr) ? pwdata[1:0] : 2'b00;

    // Read mux
    wire logic [7:0] rd_byte =
        hit_limit ? limit_cfg_reg :
        hit_pcfg ? pat_cfg_reg :
        hit_psel ? pat_sel_reg :
        hit_stat ? {6'h00, status_reg} :
        hit_ien ? {6'h00, int_en_reg} :
        hit_acc ? {2'h0, accept_reg} :
        hit_noise ? noise_cfg_reg : 8'h00;

    // Configuration fields
    wire logic blk_en = limit_cfg_reg[BLK_EN_BIT];
    wire logic [2:0] limit = {1'b0, limit_cfg_reg[LIMIT_LSB+:2]} + 3'h1;
    wire logic pd_en = pat_cfg_reg[PD_EN_BIT];
    wire logic [1:0] pth_sel = pat_cfg_reg[PTH_LSB+:2];
    wire logic cmp_mode = pat_cfg_reg[CMP_BIT];
    wire logic alert_en = pat_cfg_reg[ALERT_BIT];
    wire logic [N-1:0] pat_mask = pat_sel_reg[N-1:0];

    // Per-input qualification for this polling cycle only
    logic [N-1:0] over_full;
    logic [N-1:0] over_pat;
    logic [N-1:0] noise;
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : gen_in
            wire logic [DELTA_W-1:0] d = sample.delta[g*DELTA_W+:DELTA_W];
            wire logic [TH_W-1:0] th = sample.threshold[g*TH_W+:TH_W];
            wire logic [TH_W-1:0] base = sample.standby ? sample.standby_threshold : th;
            wire logic [TH_W-1:0] pth = pct(base, pth_sel);
            wire logic [TH_W-1:0] nth = npct(th, noise_cfg_reg[1:0]);
            assign over_full[g] = sample.touch_raw[g] && (d > {1'b0, th});
            assign over_pat[g] = d > {1'b0, pth};
            assign noise[g] = (d > {1'b0, nth}) && !(d > {1'b0, th});
        end
    endgenerate

    wire logic [N-1:0] qual = over_pat | noise;
    wire logic pat_cmp_hit = (qual & pat_mask) == pat_mask;
    wire logic pat_cnt_hit = ones(qual) >= ones(pat_mask);
    wire logic pat_cond = pd_en && (cmp_mode ? pat_cmp_hit : pat_cnt_hit);

    // Accepted set: keep while all held, rescan 1..6 otherwise
    wire logic released = |(accept_reg & ~over_full);
    logic [N-1:0] scan_set;
    logic [2:0] scan_cnt;
    always_comb
    begin
        scan_set = '0;
        scan_cnt = 3'h0;
        for (int i = 0; i < N; i++)
        begin
            if (over_full[i] && scan_cnt < limit)
            begin
                scan_set[i] = 1'b1;
                scan_cnt = scan_cnt + 3'h1;
            end
        end
    end

    wire logic [N-1:0] held_set = accept_reg & over_full;
    wire logic [N-1:0] fresh_set = (released || accept_reg == '0) ? scan_set : held_set;
    wire logic [N-1:0] keep_set = (ones(held_set) >= limit) ? held_set : fresh_set;
    wire logic over_limit = blk_en && (ones(over_full) > limit);

    // Next state of qualification
    always_comb
    begin
        accept_next = accept_reg;
        touch_out_next = touch_out_reg;
        pat_block_next = pat_block_reg;
        status_next = status_reg & ~clr_bits;
        if (sample_valid)
        begin
            pat_block_next = pat_cond;
            if (pat_cond)
            begin
                touch_out_next = '0;
                accept_next = '0;
                status_next[ST_PAT_BIT] = 1'b1;
            end
            else if (blk_en)
            begin
                accept_next = keep_set;
                touch_out_next = keep_set;
                if (over_limit)
                begin
                    status_next[ST_MULTI_BIT] = 1'b1;
                end
            end
            else
            begin
                accept_next = '0;
                touch_out_next = over_full;
            end
        end
        // Pattern flag survives host clear while condition stands
        if (pat_block_reg && clr_bits[ST_PAT_BIT])
        begin
            status_next[ST_PAT_BIT] = 1'b1;
        end
    end

    wire logic irq_next = |(status_next & int_en_reg & {alert_en, 1'b1});

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            limit_cfg_reg <= LIMIT_CFG_RST;
            pat_cfg_reg <= PAT_CFG_RST;
            pat_sel_reg <= PAT_SEL_RST;
            noise_cfg_reg <= NOISE_CFG_RST;
            int_en_reg <= INT_EN_RST;
        end
        else if (wr)
        begin
            if (hit_limit) limit_cfg_reg <= pwdata[7:0] & 8'h8c;
            if (hit_pcfg) pat_cfg_reg <= pwdata[7:0] & 8'h8f;
            if (hit_psel) pat_sel_reg <= pwdata[7:0] & 8'h3f;
            if (hit_noise) noise_cfg_reg <= pwdata[7:0] & 8'h03;
            if (hit_ien) int_en_reg <= pwdata[1:0];
        end
    end

    // Qualification state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            accept_reg <= '0;
            touch_out_reg <= '0;
            pat_block_reg <= 1'b0;
            status_reg <= 2'h0;
            irq_reg <= 1'b0;
        end
        else
        begin
            accept_reg <= accept_next;
            touch_out_reg <= touch_out_next;
            pat_block_reg <= pat_block_next;
            status_reg <= status_next;
            irq_reg <= irq_next;
        end
    end

    // APB answer: no wait state, ready in first access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end
        else
        begin
            pready_reg <= setup;
            pslverr_reg <= setup && !mapped;
            if (setup && !pwrite)
            begin
                prdata_reg <= {24'h00_0000, rd_byte};
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;
    assign result = '{touch_out: touch_out_reg, multi_flag: status_reg[ST_MULTI_BIT],
        pattern_flag: status_reg[ST_PAT_BIT]};
endmodule

// ### pkg/mtb_pkg.sv
// Package: register map, field positions, resets and carrier types of the touch qualifier
// Function
// - Bit 7 enables blocking; 0 never blocks
// - Accept limit touches, hold set until release
// - On release reselect scanning input 1 to 6
// - Limit field 00..11 means 1..4 touches
// - Exceeding limit sets multi-touch status flag
// - Blocking uses full threshold, pattern uses reduced
// - Pattern threshold 12.5, 25, 37.5, 100 percent
// - Base threshold: per-input active, standby otherwise
// - Pattern detect enable bit 7, default off
// - Compare mode: every selected input must qualify
// - Count mode: qualifying count at least ones
// - Evaluate pattern within one polling cycle only
// - Pattern event blocks all, flags, requests interrupt
// - Block while condition holds, then restore
// - Pattern flag cleared only by host clear
// - Alert enable gates pin; flag always set
// - Pattern select bits, reset value 3fh
// - Noise spike: above noise, below touch threshold
package mtb_pkg;
    localparam int NUM_INPUTS = 6;
    localparam int DELTA_W = 8;
    localparam int TH_W = 7;

    // Documented register indices (byte offset is index times four on APB)
    localparam logic [7:0] IDX_LIMIT_CFG = 8'h2a;
    localparam logic [7:0] IDX_PAT_CFG = 8'h2b;
    localparam logic [7:0] IDX_PAT_SEL = 8'h2d;
    // Own registers (indices)
    localparam logic [7:0] IDX_STATUS = 8'h40;
    localparam logic [7:0] IDX_INT_EN = 8'h41;
    localparam logic [7:0] IDX_INT_CLR = 8'h42;
    localparam logic [7:0] IDX_ACCEPT = 8'h43;
    localparam logic [7:0] IDX_NOISE_CFG = 8'h44;

    localparam logic [7:0] LIMIT_CFG_RST = 8'h80;
    localparam logic [7:0] PAT_CFG_RST = 8'h00;
    localparam logic [7:0] PAT_SEL_RST = 8'h3f;
    localparam logic [7:0] NOISE_CFG_RST = 8'h01;
    localparam logic [1:0] INT_EN_RST = 2'h3;

    localparam int BLK_EN_BIT = 7;
    localparam int LIMIT_LSB = 2;
    localparam int PD_EN_BIT = 7;
    localparam int PTH_LSB = 2;
    localparam int CMP_BIT = 1;
    localparam int ALERT_BIT = 0;
    localparam int ST_MULTI_BIT = 0;
    localparam int ST_PAT_BIT = 1;

    // One polling cycle of per-input results
    typedef struct packed {
        logic [NUM_INPUTS-1:0] touch_raw;
        logic [NUM_INPUTS*DELTA_W-1:0] delta;
        logic [NUM_INPUTS*TH_W-1:0] threshold;
        logic [TH_W-1:0] standby_threshold;
        logic standby;
    } mtb_sample_t;

    typedef struct packed {
        logic [NUM_INPUTS-1:0] touch_out;
        logic multi_flag;
        logic pattern_flag;
    } mtb_result_t;
endpackage

// ### sim/mtb_properties.sv
// Checker: bus timing, flag and touch output relations
`timescale 1ns/100ps
module mtb_props
    import mtb_pkg::*;
(
    // Bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Touch side
    input wire logic sample_valid,
    input wire mtb_sample_t sample,
    input wire mtb_result_t result,
    input wire logic irq
);
    logic [7:0] lim_reg;
    logic pen_reg;
    wire wr = psel && penable && pready && pwrite;
    wire clr = wr && paddr == 12'h108;
    wire ok = paddr inside {12'h0a8, 12'h0ac, 12'h0b4, [12'h100:12'h110]};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Shadow of configuration writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lim_reg <= 8'h80;
            pen_reg <= 1'b0;
        end
        else if (wr && paddr == 12'h0a8)
            lim_reg <= pwdata[7:0];
        else if (wr && paddr == 12'h0ac)
            pen_reg <= pwdata[7];
    end
    property p_rdy; psel && penable && !$past(penable) |-> pready ##1 !pready; endproperty
    a_rdy: assert property (p_rdy) else $error("ready not one cycle");
    property p_err; pready |-> (pslverr == !ok) && (pwrite || ok || prdata == 32'h0); endproperty
    a_err: assert property (p_err) else $error("bad slave error");
    property p_irq; irq |-> result.multi_flag || result.pattern_flag; endproperty
    a_irq: assert property (p_irq) else $error("irq without flag");
    property p_lim; sample_valid && lim_reg[7] |=> $countones(result.touch_out) <= lim_reg[3:2] + 1;
    endproperty
    a_lim: assert property (p_lim) else $error("too many touches");
    property p_sub; sample_valid |=> (result.touch_out & ~$past(sample.touch_raw)) == 6'h0;
    endproperty
    a_sub: assert property (p_sub) else $error("untouched input flagged");
    property p_hold; !sample_valid && !(psel && pwrite) |=> $stable(result.touch_out); endproperty
    a_hold: assert property (p_hold) else $error("touch set moved");
    property p_pclr; $fell(result.pattern_flag) |-> $past(clr && pwdata[1]); endproperty
    a_pclr: assert property (p_pclr) else $error("pattern flag lost");
    property p_mclr; $fell(result.multi_flag) |-> $past(clr && pwdata[0]); endproperty
    a_mclr: assert property (p_mclr) else $error("multi flag lost");
    property p_pon; $rose(result.pattern_flag) |-> $past(sample_valid && pen_reg); endproperty
    a_pon: assert property (p_pon) else $error("event while disabled");
    property p_pblk; $rose(result.pattern_flag) |-> result.touch_out == 6'h0; endproperty
    a_pblk: assert property (p_pblk) else $error("event not blocking");
    c_pat: cover property (sample_valid ##1 $rose(result.pattern_flag));
    c_err: cover property (pready && pslverr);
    c_irq: cover property ($rose(irq));
endmodule
bind mtb_touch_qualify mtb_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid), .sample(sample),
    .result(result), .irq(irq));

// ### sim/mtb_sensor_model.sv
// Sensor front end model: one polling cycle result per request
`timescale 1ns/100ps
module mtb_sensor_model
    import mtb_pkg::*;
(
    // Request
    input wire logic pclk,
    input wire logic go,
    input wire logic [5:0] raw,
    input wire logic [5:0] dmask,
    input wire logic [7:0] dval,
    input wire logic stby,
    // Result port
    output logic sample_valid,
    output mtb_sample_t sample
);
    // One pulse per request; data scrambled outside it
    always_ff @(posedge pclk)
    begin
        sample_valid <= go;
        sample.touch_raw <= go ? raw : ~sample.touch_raw;
        sample.standby <= stby;
        sample.standby_threshold <= 7'h08;
        for (int i = 0; i < NUM_INPUTS; i++)
        begin
            sample.delta[i*8 +: 8] <= go ? (dmask[i] ? dval : 8'h00) : ~sample.delta[i*8 +: 8];
            sample.threshold[i*7 +: 7] <= 7'h40;
        end
    end
endmodule

// ### sim/test_multi_touch_block_and_pattern_detect.sv
// Testbench: register access, touch limiting and pattern events
`timescale 1ns/100ps
module test_multi_touch_block_and_pattern_detect;
    import mtb_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, stby = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd, prdata;
    logic [5:0] raw = 0, dmask = 0;
    logic [7:0] dval = 0;
    logic pready, pslverr, err, sample_valid, irq;
    mtb_sample_t sample;
    mtb_result_t result;
    int n_mismatch = 0, checks_done = 0;
    // Config, mask, delta, standby, expected pattern flag
    logic [31:0] tv [15] = '{32'h82030800, 32'h82030901, 32'h86031000, 32'h86031101,
        32'h8a031800, 32'h8a031901, 32'h8e032800, 32'h8e032901, 32'h80300a01,
        32'h80100a00, 32'h82300a00, 32'h82030a01, 32'h80300211, 32'h80300200, 32'h003f5000};
    mtb_touch_qualify dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_valid(sample_valid), .sample(sample), .result(result),
        .irq(irq));
    mtb_sensor_model model (.pclk(pclk), .go(go), .raw(raw), .dmask(dmask), .dval(dval),
        .stby(stby), .sample_valid(sample_valid), .sample(sample));
    // Clock
    initial
    begin
        forever #2.5 pclk = ~pclk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t = 0;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1 && ++t < 20);
        rd = prdata;
        err = pslverr;
        chk("pready", 1, pready);
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 0);
        chk(nm, e, rd);
    endtask
    task automatic send(input logic [5:0] r, m, input logic [7:0] v, input logic s);
        @(posedge pclk);
        raw <= r;
        dmask <= m;
        dval <= v;
        stby <= s;
        go <= 1;
        @(posedge pclk);
        go <= 0;
        repeat (3) @(posedge pclk);
    endtask
    task automatic idle_clr();
        send(0, 0, 0, 0);
        apb(1, 12'h108, 32'h3);
    endtask
    task automatic end_sim();
        $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        #200000;
        n_mismatch++;
        end_sim();
    end
    // Main sequence
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        rdc("limit_cfg", 12'h0a8, 32'h80);
        rdc("pat_cfg", 12'h0ac, 32'h00);
        rdc("pat_sel", 12'h0b4, 32'h3f);
        rdc("int_en", 12'h104, 32'h3);
        rdc("unmapped", 12'h0fc, 32'h0);
        chk("slverr", 1, err);
        for (int k = 0; k < 4; k++)
        begin
            apb(1, 12'h0a8, 32'h80 | (k << 2));
            send(0, 6'h3f, 0, 0);
            send(6'h3f, 6'h3f, 8'h50, 0);
            chk("limited", (32'h1 << (k + 1)) - 1, result.touch_out);
            chk("multi", 1, result.multi_flag);
        end
        apb(1, 12'h0a8, 32'h84);
        send(0, 0, 0, 0);
        send(6'h0c, 6'h3f, 8'h50, 0);
        send(6'h3f, 6'h3f, 8'h50, 0);
        chk("held", 32'h0c, result.touch_out);
        send(6'h3b, 6'h3f, 8'h50, 0);
        chk("rescan", 32'h03, result.touch_out);
        rdc("accepted", 12'h10c, 32'h03);
        chk("irq", 1, irq);
        apb(1, 12'h104, 32'h0);
        rdc("status", 12'h100, 32'h1);
        chk("irq_mask", 0, irq);
        apb(1, 12'h104, 32'h2);
        idle_clr();
        rdc("status_clr", 12'h100, 32'h0);
        apb(1, 12'h0a8, 32'h00);
        send(6'h3f, 6'h3f, 8'h50, 0);
        chk("unblocked", 32'h3f, result.touch_out);
        apb(1, 12'h110, 32'h3);
        apb(1, 12'h0b4, 32'h03);
        foreach (tv[i])
        begin
            apb(1, 12'h0ac, {24'h0, tv[i][31:24]});
            idle_clr();
            send(tv[i][21:16], tv[i][21:16], tv[i][15:8], tv[i][4]);
            chk("pattern", tv[i][0], result.pattern_flag);
            chk("irq_off", 0, irq);
        end
        apb(1, 12'h0ac, 32'h83);
        idle_clr();
        send(6'h01, 6'h01, 8'h50, 0);
        send(6'h02, 6'h02, 8'h50, 0);
        chk("split", 0, result.pattern_flag);
        send(6'h3f, 6'h3f, 8'h50, 0);
        chk("blocked", 0, result.touch_out);
        chk("irq_pat", 1, irq);
        apb(1, 12'h108, 32'h2);
        chk("pat_held", 1, result.pattern_flag);
        send(6'h04, 6'h04, 8'h50, 0);
        chk("restored", 32'h04, result.touch_out);
        chk("sticky", 1, result.pattern_flag);
        apb(1, 12'h108, 32'h2);
        apb(0, 12'h100, 0);
        chk("pat_clr", 0, rd[1]);
        end_sim();
    end
endmodule
